// file: verilog/afd_pkg.sv
// afd_pkg: constants and types for the arithmetic, flag and
// dual data pointer datapath.
// assumes one core clock; the decoder drives the op codes below.
package afd_pkg;

	// special-function addresses
	localparam logic [7:0] AFD_CTRL_ADDR   = 8'hA7;
	localparam logic [7:0] AFD_PTR_LO_ADDR = 8'h82;
	localparam logic [7:0] AFD_PTR_HI_ADDR = 8'h83;

	// data_pointer_control fields
	localparam int         AFD_SEL_BIT        = 0;
	localparam int         AFD_MAIN_MODE_LSB  = 2;
	localparam int         AFD_SHAD_MODE_LSB  = 4;
	localparam int         AFD_SWAP_BIT       = 6;
	localparam int         AFD_UNUSED_BIT     = 7;
	localparam logic [7:0] AFD_CTRL_WMASK     = 8'h7D;
	localparam logic [7:0] AFD_CTRL_RESET     = 8'h00;

	// pointer update modes
	localparam logic [1:0] AFD_MODE_HOLD = 2'b00;
	localparam logic [1:0] AFD_MODE_INC  = 2'b01;
	localparam logic [1:0] AFD_MODE_DEC  = 2'b10;
	localparam logic [1:0] AFD_MODE_FLIP = 2'b11;

	// decimal adjust constants
	localparam logic [3:0] AFD_NIBBLE_MAX = 4'h9;
	localparam logic [8:0] AFD_DA_LOW_FIX = 9'h006;
	localparam logic [8:0] AFD_DA_HI_FIX  = 9'h060;
	localparam logic [8:0] AFD_DA_LIMIT   = 9'h099;

	// carry tap positions
	localparam int AFD_AUX_BIT = 4;
	localparam int AFD_C6_BIT  = 7;
	localparam int AFD_C7_BIT  = 8;

	typedef enum logic [3:0] {
		AFD_OP_ADD,
		AFD_OP_ADDC,
		AFD_OP_SUBB,
		AFD_OP_MUL,
		AFD_OP_DIV,
		AFD_OP_DA,
		AFD_OP_RRC,
		AFD_OP_RLC,
		AFD_OP_CJNE
	} afd_op_t;

	typedef enum logic [1:0] {
		AFD_MV_MOVC_DPTR,
		AFD_MV_MOVX_DPTR,
		AFD_MV_MOVC_PC,
		AFD_MV_MOVX_RI
	} afd_move_t;

endpackage : afd_pkg

// file: verilog/afd_alu_flags_dual_dptr.sv
// afd_alu_flags_dual_dptr: arithmetic/flag datapath and the dual
// data pointer unit with its control register.
// assumes the decoder keeps the flag register and feeds it back in,
// and presents at most one op and one pointer event per cycle.
// Operation
// - add sets carry bit7, aux bit3
// - add with carry includes carry flag
// - add overflow is carry6 xor carry7
// - subtract source and borrow, borrows set flags
// - subtract overflow is borrow6 xor borrow7
// - multiply splits product, overflow above 255
// - divide gives quotient, remainder, clears carry
// - divide by zero sets overflow
// - decimal adjust adds 06 when low needs
// - decimal adjust adds 60 on carry or step
// - decimal adjust carry when result above 99
// - rotate right through carry
// - rotate left through carry
// - compare branches when operands differ
// - compare carry when source above destination
// - two pointers chosen by control register
// - pointer accesses use the active pointer
// - only pointer-addressed moves update the pointer
// - bit 6 enables swap after moves
// - bit 7 unimplemented, reads zero
// - bits 5:4 shadow pointer update mode
// - bits 3:2 main pointer update mode
// - modes hold, increment, decrement, flip lsb
`timescale 1ns/1ns
module afd_alu_flags_dual_dptr
	import afd_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        opValid,
	input  wire afd_op_t     opCode,
	input  wire logic [7:0]  accIn,
	input  wire logic [7:0]  srcIn,
	input  wire logic [7:0]  bIn,
	input  wire logic        carryIn,
	input  wire logic        auxCarryIn,
	input  wire logic        ovIn,
	output logic             resultValid,
	output logic      [7:0]  accOut,
	output logic      [7:0]  bOut,
	output logic             carryOut,
	output logic             auxCarryOut,
	output logic             overflowOut,
	output logic             branchTaken,
	input  wire logic        ptrLoad,
	input  wire logic [15:0] ptrLoadValue,
	input  wire logic        ptrMove,
	input  wire afd_move_t   ptrMoveKind,
	output logic      [15:0] activePtr,
	output logic             activeIsShadow,
	input  wire logic [7:0]  sfrAddr,
	input  wire logic        sfrWrite,
	input  wire logic        sfrRead,
	input  wire logic [7:0]  sfrWdata,
	output logic      [7:0]  sfrRdata,
	output logic             sfrRdValid
);

	typedef struct packed {
		logic [7:0]  acc;
		logic [7:0]  b;
		logic        carry;
		logic        aux;
		logic        ov;
		logic        branch;
		logic        resValid;
		logic [7:0]  ctrl;
		logic [15:0] mainPtr;
		logic [15:0] shadowPtr;
		logic [7:0]  rdData;
		logic        rdValid;
	} afd_state_t;

	afd_state_t st;
	afd_state_t next_st;

	// one post-move pointer step for a given mode
	function automatic logic [15:0] afdPtrStep(input logic [15:0] ptr,
		input logic [1:0] mode);
		logic [15:0] res;
		res = ptr;
		case (mode)
			AFD_MODE_INC:  res = ptr + 16'h0001;
			AFD_MODE_DEC:  res = ptr - 16'h0001;
			AFD_MODE_FLIP: res = ptr ^ 16'h0001;
			default:       res = ptr;
		endcase
		return res;
	endfunction : afdPtrStep

	// next state: alu result, then register port, then pointer events
	always_comb begin
		logic        cin;
		logic [4:0]  lo;
		logic [7:0]  mid;
		logic [8:0]  full;
		logic [15:0] prod;
		logic        step1;
		logic        step2;
		logic [8:0]  da1;
		logic [8:0]  da2;
		logic [15:0] curPtr;
		logic        useShadow;
		cin       = 1'b0;
		lo        = 5'h00;
		mid       = 8'h00;
		full      = 9'h000;
		prod      = 16'h0000;
		step1     = 1'b0;
		step2     = 1'b0;
		da1       = 9'h000;
		da2       = 9'h000;
		useShadow = st.ctrl[AFD_SEL_BIT];
		curPtr    = useShadow ? st.shadowPtr : st.mainPtr;
		next_st          = st;
		next_st.resValid = 1'b0;
		next_st.rdValid  = 1'b0;
		next_st.rdData   = 8'h00;

		if (opValid) begin
			next_st.resValid = 1'b1;
			next_st.acc      = accIn;
			next_st.b        = bIn;
			next_st.carry    = carryIn;
			next_st.aux      = auxCarryIn;
			next_st.ov       = ovIn;
			next_st.branch   = 1'b0;
			case (opCode)
				AFD_OP_ADD, AFD_OP_ADDC: begin
					cin  = (opCode == AFD_OP_ADDC) & carryIn;
					lo   = {1'b0, accIn[3:0]} + {1'b0, srcIn[3:0]}
						+ {4'h0, cin};
					mid  = {1'b0, accIn[6:0]} + {1'b0, srcIn[6:0]}
						+ {7'h00, cin};
					full = {1'b0, accIn} + {1'b0, srcIn} + {8'h00, cin};
					next_st.acc   = full[7:0];
					next_st.carry = full[AFD_C7_BIT];
					next_st.aux   = lo[AFD_AUX_BIT];
					next_st.ov    = mid[AFD_C6_BIT] ^ full[AFD_C7_BIT];
				end
				AFD_OP_SUBB: begin
					cin  = carryIn;
					lo   = {1'b0, accIn[3:0]} - {1'b0, srcIn[3:0]}
						- {4'h0, cin};
					mid  = {1'b0, accIn[6:0]} - {1'b0, srcIn[6:0]}
						- {7'h00, cin};
					full = {1'b0, accIn} - {1'b0, srcIn} - {8'h00, cin};
					next_st.acc   = full[7:0];
					next_st.carry = full[AFD_C7_BIT];
					next_st.aux   = lo[AFD_AUX_BIT];
					next_st.ov    = mid[AFD_C6_BIT] ^ full[AFD_C7_BIT];
				end
				AFD_OP_MUL: begin
					prod = {8'h00, accIn} * {8'h00, bIn};
					next_st.acc   = prod[7:0];
					next_st.b     = prod[15:8];
					next_st.carry = 1'b0;
					next_st.ov    = |prod[15:8];
				end
				AFD_OP_DIV: begin
					next_st.carry = 1'b0;
					if (bIn == 8'h00) begin
						next_st.ov = 1'b1;
					end else begin
						next_st.acc = accIn / bIn;
						next_st.b   = accIn % bIn;
						next_st.ov  = 1'b0;
					end
				end
				AFD_OP_DA: begin
					step1 = auxCarryIn | (accIn[3:0] > AFD_NIBBLE_MAX);
					da1   = {1'b0, accIn} + (step1 ? AFD_DA_LOW_FIX : 9'h000);
					step2 = carryIn | step1;
					da2   = da1 + (step2 ? AFD_DA_HI_FIX : 9'h000);
					next_st.acc   = da2[7:0];
					next_st.carry = da2 > AFD_DA_LIMIT;
				end
				AFD_OP_RRC: begin
					next_st.acc   = {carryIn, accIn[7:1]};
					next_st.carry = accIn[0];
				end
				AFD_OP_RLC: begin
					next_st.acc   = {accIn[6:0], carryIn};
					next_st.carry = accIn[7];
				end
				AFD_OP_CJNE: begin
					next_st.branch = accIn != srcIn;
					next_st.carry  = srcIn > accIn;
				end
				default: begin
					next_st.resValid = 1'b0;
				end
			endcase
		end

		// register port writes
		if (sfrWrite) begin
			if (sfrAddr == AFD_CTRL_ADDR) begin
				next_st.ctrl = sfrWdata & AFD_CTRL_WMASK;
			end else if (sfrAddr == AFD_PTR_LO_ADDR) begin
				if (useShadow) begin
					next_st.shadowPtr[7:0] = sfrWdata;
				end else begin
					next_st.mainPtr[7:0] = sfrWdata;
				end
			end else if (sfrAddr == AFD_PTR_HI_ADDR) begin
				if (useShadow) begin
					next_st.shadowPtr[15:8] = sfrWdata;
				end else begin
					next_st.mainPtr[15:8] = sfrWdata;
				end
			end
		end

		// register port reads, answered one cycle later
		if (sfrRead) begin
			if (sfrAddr == AFD_CTRL_ADDR) begin
				next_st.rdData  = st.ctrl;
				next_st.rdValid = 1'b1;
			end else if (sfrAddr == AFD_PTR_LO_ADDR) begin
				next_st.rdData  = curPtr[7:0];
				next_st.rdValid = 1'b1;
			end else if (sfrAddr == AFD_PTR_HI_ADDR) begin
				next_st.rdData  = curPtr[15:8];
				next_st.rdValid = 1'b1;
			end
		end

		// immediate load of the active pointer
		if (ptrLoad) begin
			if (useShadow) begin
				next_st.shadowPtr = ptrLoadValue;
			end else begin
				next_st.mainPtr = ptrLoadValue;
			end
		end

		// move completion: step the used pointer, then maybe swap
		if (ptrMove) begin
			if (ptrMoveKind == AFD_MV_MOVC_DPTR ||
				ptrMoveKind == AFD_MV_MOVX_DPTR) begin
				if (useShadow) begin
					next_st.shadowPtr = afdPtrStep(st.shadowPtr,
						st.ctrl[AFD_SHAD_MODE_LSB +: 2]);
				end else begin
					next_st.mainPtr = afdPtrStep(st.mainPtr,
						st.ctrl[AFD_MAIN_MODE_LSB +: 2]);
				end
			end
			if (st.ctrl[AFD_SWAP_BIT]) begin
				next_st.ctrl[AFD_SEL_BIT] = ~next_st.ctrl[AFD_SEL_BIT];
			end
		end
	end

	// state register, synchronous reset
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st      <= '0;
			st.ctrl <= AFD_CTRL_RESET;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from state
	assign resultValid    = st.resValid;
	assign accOut         = st.acc;
	assign bOut           = st.b;
	assign carryOut       = st.carry;
	assign auxCarryOut    = st.aux;
	assign overflowOut    = st.ov;
	assign branchTaken    = st.branch;
	assign activeIsShadow = st.ctrl[AFD_SEL_BIT];
	assign activePtr      = st.ctrl[AFD_SEL_BIT] ? st.shadowPtr
		: st.mainPtr;
	assign sfrRdata       = st.rdData;
	assign sfrRdValid     = st.rdValid;

	// alu results, flags and pointer behaviour against reference expressions
	AST_ADD_CARRY: assert property (@(posedge clk_sys) disable iff (!rst_n)
		opValid && opCode == AFD_OP_ADD |=> resultValid && carryOut ==
		(({1'b0, $past(accIn)} + {1'b0, $past(srcIn)}) > 9'h0FF))
		else $error("add carry wrong");
	AST_ADD_AUX: assert property (@(posedge clk_sys) disable iff (!rst_n)
		opValid && opCode == AFD_OP_ADD |=> auxCarryOut ==
		((($past(accIn) & 8'h0F) + ($past(srcIn) & 8'h0F)) > 8'h0F))
		else $error("add aux carry wrong");
	AST_ADDC_SUM: assert property (@(posedge clk_sys) disable iff (!rst_n)
		opValid && opCode == AFD_OP_ADDC |=> accOut == $past(accIn)
		+ $past(srcIn) + {7'h00, $past(carryIn)})
		else $error("add with carry sum wrong");
	AST_ADD_OV: assert property (@(posedge clk_sys) disable iff (!rst_n)
		opValid && opCode == AFD_OP_ADD && accIn[7] == srcIn[7] |=>
		overflowOut == (accOut[7] != $past(accIn[7])))
		else $error("add overflow wrong");
	AST_SUBB_CARRY: assert property (@(posedge clk_sys) disable iff (!rst_n)
		opValid && opCode == AFD_OP_SUBB |=> carryOut ==
		(({1'b0, $past(srcIn)} + {8'h00, $past(carryIn)})
		> {1'b0, $past(accIn)}))
		else $error("subtract borrow wrong");
	AST_MUL: assert property (@(posedge clk_sys) disable iff (!rst_n)
		opValid && opCode == AFD_OP_MUL |=> {bOut, accOut} ==
		$past(accIn) * $past(bIn) && !carryOut && overflowOut ==
		(bOut != 8'h00))
		else $error("multiply wrong");
	AST_DIV: assert property (@(posedge clk_sys) disable iff (!rst_n)
		opValid && opCode == AFD_OP_DIV && bIn != 8'h00 |=>
		accOut == $past(accIn) / $past(bIn) && bOut == $past(accIn)
		% $past(bIn) && !carryOut && !overflowOut)
		else $error("divide wrong");
	AST_DIV_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
		opValid && opCode == AFD_OP_DIV && bIn == 8'h00 |=>
		overflowOut && !carryOut)
		else $error("divide by zero flags wrong");
	AST_RRC: assert property (@(posedge clk_sys) disable iff (!rst_n)
		opValid && opCode == AFD_OP_RRC |=> carryOut == $past(accIn[0])
		&& accOut[7] == $past(carryIn))
		else $error("rotate right wrong");
	AST_RLC: assert property (@(posedge clk_sys) disable iff (!rst_n)
		opValid && opCode == AFD_OP_RLC |=> carryOut == $past(accIn[7])
		&& accOut[0] == $past(carryIn))
		else $error("rotate left wrong");
	AST_CJNE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		opValid && opCode == AFD_OP_CJNE |=> branchTaken ==
		($past(accIn) != $past(srcIn)) && carryOut ==
		($past(srcIn) > $past(accIn)))
		else $error("compare result wrong");
	AST_CTRL_BIT7: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!st.ctrl[AFD_UNUSED_BIT])
		else $error("unimplemented control bit set");
	AST_SWAP: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ptrMove && st.ctrl[AFD_SWAP_BIT] && !sfrWrite |=>
		activeIsShadow != $past(activeIsShadow))
		else $error("pointer swap missing");
	AST_MAIN_INC: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ptrMove && ptrMoveKind == AFD_MV_MOVX_DPTR && !activeIsShadow &&
		st.ctrl[AFD_MAIN_MODE_LSB +: 2] == AFD_MODE_INC && !sfrWrite &&
		!ptrLoad |=> st.mainPtr == $past(st.mainPtr) + 16'h0001)
		else $error("main pointer increment wrong");
	AST_PC_FORM: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ptrMove && (ptrMoveKind == AFD_MV_MOVC_PC ||
		ptrMoveKind == AFD_MV_MOVX_RI) && !sfrWrite && !ptrLoad |=>
		$stable(st.mainPtr) && $stable(st.shadowPtr))
		else $error("pointer changed by non-pointer move");

endmodule : afd_alu_flags_dual_dptr

// file: tb/afd_dec_model.sv
// afd_dec_model: decoder and sequencer stand-in that issues ops,
// pointer events and special-function accesses to the datapath.
// assumes a rising-edge datapath; requests change at the falling edge.
`timescale 1ns/1ns
module afd_dec_model
	import afd_pkg::*;
(
	input  wire logic        clk_sys,
	output logic             opValid,
	output afd_op_t          opCode,
	output logic      [7:0]  accIn,
	output logic      [7:0]  srcIn,
	output logic      [7:0]  bIn,
	output logic             carryIn,
	output logic             auxCarryIn,
	output logic             ovIn,
	input  wire logic        resultValid,
	output logic             ptrLoad,
	output logic      [15:0] ptrLoadValue,
	output logic             ptrMove,
	output afd_move_t        ptrMoveKind,
	output logic      [7:0]  sfrAddr,
	output logic             sfrWrite,
	output logic             sfrRead,
	output logic      [7:0]  sfrWdata,
	input  wire logic [7:0]  sfrRdata,
	input  wire logic        sfrRdValid
);
	// idle values at time zero
	initial begin
		{opValid, ptrLoad, ptrMove, sfrWrite, sfrRead} = 5'h00;
		{carryIn, auxCarryIn, ovIn} = 3'h0;
		{accIn, srcIn, bIn, sfrAddr, sfrWdata} = 40'h00_0000_0000;
		opCode = AFD_OP_ADD;
		ptrMoveKind = AFD_MV_MOVC_DPTR;
		ptrLoadValue = 16'h0000;
	end

	// one op pulse; operands inverted once released
	task automatic alu(input afd_op_t op, input logic [7:0] a, s,
		input logic [2:0] f, output logic ok);
		@(negedge clk_sys);
		opValid = 1'b1;
		opCode = op;
		accIn = a;
		srcIn = s;
		bIn = s;
		{carryIn, auxCarryIn, ovIn} = f;
		@(negedge clk_sys);
		ok = resultValid;
		opValid = 1'b0;
		accIn = ~a;
		srcIn = ~s;
		bIn = ~s;
	endtask : alu

	// one special-function write or read pulse
	task automatic sfr(input logic wr, input logic [7:0] ad, d,
		output logic [7:0] q, output logic ok);
		@(negedge clk_sys);
		sfrWrite = wr;
		sfrRead = ~wr;
		sfrAddr = ad;
		sfrWdata = d;
		@(negedge clk_sys);
		ok = sfrRdValid;
		q = sfrRdata;
		{sfrWrite, sfrRead} = 2'h0;
		sfrAddr = ~ad;
		sfrWdata = ~d;
	endtask : sfr

	// one pointer load or move pulse, never both
	task automatic ptr(input logic mv, input afd_move_t k,
		input logic [15:0] v);
		@(negedge clk_sys);
		ptrMove = mv;
		ptrLoad = ~mv;
		ptrMoveKind = k;
		ptrLoadValue = v;
		@(negedge clk_sys);
		{ptrMove, ptrLoad} = 2'h0;
		ptrLoadValue = ~v;
	endtask : ptr
endmodule : afd_dec_model

// file: tb/testbench.sv
// testbench: self-checking scenarios for the datapath and pointers.
// assumes afd_dec_model drives all requests at the falling edge.
`timescale 1ns/1ns
module testbench
	import afd_pkg::*;
	;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic opValid, carryIn, auxCarryIn, ovIn, resultValid;
	logic carryOut, auxCarryOut, overflowOut, branchTaken;
	logic ptrLoad, ptrMove, activeIsShadow;
	logic sfrWrite, sfrRead, sfrRdValid, ok;
	logic [7:0] accIn, srcIn, bIn, accOut, bOut, q;
	logic [7:0] sfrAddr, sfrWdata, sfrRdata;
	logic [15:0] ptrLoadValue, activePtr;
	afd_op_t opCode;
	afd_move_t ptrMoveKind;
	int failures = 0;
	int cmp_count = 0;
	int cyc = 0;

	afd_alu_flags_dual_dptr dut (.clk_sys, .rst_n, .opValid, .opCode,
		.accIn, .srcIn, .bIn, .carryIn, .auxCarryIn, .ovIn, .resultValid,
		.accOut, .bOut, .carryOut, .auxCarryOut, .overflowOut,
		.branchTaken, .ptrLoad, .ptrLoadValue, .ptrMove, .ptrMoveKind,
		.activePtr, .activeIsShadow, .sfrAddr, .sfrWrite, .sfrRead,
		.sfrWdata, .sfrRdata, .sfrRdValid);
	afd_dec_model dec (.clk_sys, .opValid, .opCode, .accIn, .srcIn,
		.bIn, .carryIn, .auxCarryIn, .ovIn, .resultValid, .ptrLoad,
		.ptrLoadValue, .ptrMove, .ptrMoveKind, .sfrAddr, .sfrWrite,
		.sfrRead, .sfrWdata, .sfrRdata, .sfrRdValid);

	// core clock, 10 ns period
	always #5 clk_sys = ~clk_sys;

	// hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc > 3000) begin
			failures++;
			final_report();
		end
	end

	task automatic final_report();
		if (failures == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report

	task automatic chk(input string nm, input logic [15:0] e, g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	// op, then result pulse, acc and flags {c,ac,ov,branch}
	task automatic ra(input afd_op_t op, input logic [7:0] a, s,
		input logic [2:0] f, input logic [7:0] ea, input logic [3:0] ef);
		dec.alu(op, a, s, f, ok);
		chk("resultValid", 16'h0001, {15'h0000, ok});
		if (op != AFD_OP_CJNE) chk("acc", {8'h00, ea}, {8'h00, accOut});
		chk("flags", {12'h000, ef},
			{12'h000, carryOut, auxCarryOut, overflowOut, branchTaken});
	endtask : ra

	task automatic cb(input logic [7:0] eb);
		chk("b", {8'h00, eb}, {8'h00, bOut});
	endtask : cb

	// special-function access, read data and valid checked
	task automatic sf(input logic wr, input logic [7:0] ad, d, e);
		dec.sfr(wr, ad, d, q, ok);
		chk("rdValid", {15'h0000, ~wr && (ad == AFD_CTRL_ADDR ||
			ad == AFD_PTR_LO_ADDR || ad == AFD_PTR_HI_ADDR)},
			{15'h0000, ok});
		if (!wr) chk("rdata", {8'h00, e}, {8'h00, q});
	endtask : sf

	// pointer event, then active pointer and select
	task automatic pm(input logic mv, input afd_move_t k,
		input logic [15:0] v, e, input logic sh);
		dec.ptr(mv, k, v);
		chk("ptr", e, activePtr);
		chk("shadow", {15'h0000, sh}, {15'h0000, activeIsShadow});
	endtask : pm

	task automatic t_add();
		ra(AFD_OP_ADD, 8'h7F, 8'h01, 3'h0, 8'h80, 4'h6);
		ra(AFD_OP_ADD, 8'hFF, 8'h01, 3'h4, 8'h00, 4'hC);
		ra(AFD_OP_ADDC, 8'h7F, 8'h00, 3'h4, 8'h80, 4'h6);
	endtask : t_add

	task automatic t_sub();
		ra(AFD_OP_SUBB, 8'h80, 8'h01, 3'h4, 8'h7E, 4'h6);
		ra(AFD_OP_SUBB, 8'h00, 8'h00, 3'h4, 8'hFF, 4'hC);
	endtask : t_sub

	task automatic t_muldiv();
		ra(AFD_OP_MUL, 8'h10, 8'h10, 3'h5, 8'h00, 4'h2);
		cb(8'h01);
		ra(AFD_OP_MUL, 8'h0F, 8'h11, 3'h5, 8'hFF, 4'h0);
		cb(8'h00);
		ra(AFD_OP_DIV, 8'hFB, 8'h0A, 3'h5, 8'h19, 4'h0);
		cb(8'h01);
		ra(AFD_OP_DIV, 8'h55, 8'h00, 3'h4, 8'h55, 4'h2);
	endtask : t_muldiv

	task automatic t_da();
		ra(AFD_OP_DA, 8'h9A, 8'h00, 3'h0, 8'h00, 4'h8);
		ra(AFD_OP_DA, 8'h45, 8'h00, 3'h4, 8'hA5, 4'h8);
		ra(AFD_OP_DA, 8'h32, 8'h00, 3'h2, 8'h98, 4'h4);
	endtask : t_da

	task automatic t_rot_cmp();
		ra(AFD_OP_RRC, 8'h01, 8'h00, 3'h0, 8'h00, 4'h8);
		ra(AFD_OP_RRC, 8'h02, 8'h00, 3'h4, 8'h81, 4'h0);
		ra(AFD_OP_RLC, 8'h80, 8'h00, 3'h4, 8'h01, 4'h8);
		ra(AFD_OP_CJNE, 8'h05, 8'h06, 3'h0, 8'h00, 4'h9);
		ra(AFD_OP_CJNE, 8'h07, 8'h07, 3'h4, 8'h00, 4'h0);
		ra(AFD_OP_CJNE, 8'h09, 8'h03, 3'h4, 8'h00, 4'h1);
	endtask : t_rot_cmp

	task automatic t_reg();
		sf(1'b0, AFD_CTRL_ADDR, 8'h00, 8'h00);
		sf(1'b1, AFD_CTRL_ADDR, 8'hFF, 8'h00);
		sf(1'b0, AFD_CTRL_ADDR, 8'h00, 8'h7D);
		sf(1'b0, 8'h90, 8'h00, 8'h00);
		sf(1'b1, AFD_CTRL_ADDR, 8'h00, 8'h00);
		sf(1'b1, AFD_PTR_LO_ADDR, 8'h5A, 8'h00);
		sf(1'b1, AFD_PTR_HI_ADDR, 8'hC3, 8'h00);
		chk("ptrWr", 16'hC35A, activePtr);
	endtask : t_reg

	task automatic t_ptr();
		pm(1'b0, AFD_MV_MOVC_DPTR, 16'h1000, 16'h1000, 1'b0);
		sf(1'b1, AFD_CTRL_ADDR, 8'h01, 8'h00);
		pm(1'b0, AFD_MV_MOVC_DPTR, 16'h2034, 16'h2034, 1'b1);
		sf(1'b0, AFD_PTR_LO_ADDR, 8'h00, 8'h34);
		sf(1'b0, AFD_PTR_HI_ADDR, 8'h00, 8'h20);
		sf(1'b1, AFD_CTRL_ADDR, 8'h65, 8'h00);
		pm(1'b1, AFD_MV_MOVC_DPTR, 16'h0000, 16'h1000, 1'b0);
		pm(1'b1, AFD_MV_MOVX_DPTR, 16'h0000, 16'h2033, 1'b1);
		pm(1'b1, AFD_MV_MOVC_PC, 16'h0000, 16'h1001, 1'b0);
		sf(1'b1, AFD_CTRL_ADDR, 8'h0C, 8'h00);
		pm(1'b1, AFD_MV_MOVX_RI, 16'h0000, 16'h1001, 1'b0);
		pm(1'b1, AFD_MV_MOVX_DPTR, 16'h0000, 16'h1000, 1'b0);
		sf(1'b1, AFD_CTRL_ADDR, 8'h00, 8'h00);
		pm(1'b1, AFD_MV_MOVX_DPTR, 16'h0000, 16'h1000, 1'b0);
	endtask : t_ptr

	// mid-run reset drops select, modes and pointers
	task automatic t_rst();
		sf(1'b1, AFD_CTRL_ADDR, 8'h55, 8'h00);
		@(negedge clk_sys);
		rst_n = 1'b0;
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		chk("rstPtr", 16'h0000, activePtr);
		chk("rstSel", 16'h0000, {15'h0000, activeIsShadow});
		chk("rstValid", 16'h0000, {15'h0000, resultValid});
		sf(1'b0, AFD_CTRL_ADDR, 8'h00, 8'h00);
		pm(1'b1, AFD_MV_MOVX_DPTR, 16'h0000, 16'h0000, 1'b0);
	endtask : t_rst

	// reset, then every scenario in turn
	initial begin
		repeat (20) @(negedge clk_sys);
		rst_n = 1'b1;
		t_add();
		t_sub();
		t_muldiv();
		t_da();
		t_rot_cmp();
		t_reg();
		t_ptr();
		t_rst();
		final_report();
	end
endmodule : testbench
